// ### src/pms_defines.vh
// Constants for the message SPI slave port: status byte layout,
// frame byte positions, buffer geometry and interrupt flag positions.
// Included by bare name from the design files; definitions only.
`ifndef PMS_DEFINES_VH
`define PMS_DEFINES_VH

// ****************************************************************
// Status byte
// ****************************************************************
`define PMS_STAT_RECEIVE_READY_FLAG_BIT 0
`define PMS_STAT_TXQ_BIT 1

// ****************************************************************
// Frame byte positions
// ****************************************************************
`define PMS_BYTE_STATUS_IN 9'h000
`define PMS_BYTE_PAD_IN 9'h001
`define PMS_BYTE_LEN 9'h002
`define PMS_BYTE_PAYLOAD 9'h003
`define PMS_BYTE_CNT_MAX 9'h1ff
`define PMS_PAD_BYTE 8'h00

// ****************************************************************
// Buffers
// ****************************************************************
`define PMS_WORD_ADDR_W 6
`define PMS_MAX_WORDS 7'h40
`define PMS_MAX_WORDS_BYTE 8'h40

// ****************************************************************
// Internal interrupt flags and reset values
// ****************************************************************
`define PMS_INT_XACT_BIT 0
`define PMS_INT_RX_BIT 1
`define PMS_INT_RST 2'h0
`define PMS_SYNC_RST 1'b1

`endif

// ### src/pms_sync.v
// Two flip-flop synchroniser for a group of unrelated level inputs.
// Assumes each bit is sampled on its own; no bus coherence implied.
`timescale 1ns/1ps

module pms_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire CLK,
    input wire SYS_RST,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            meta_reg <= RST_VAL;
            sync_out <= RST_VAL;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // pms_sync

// ### src/pms_msg_mem.v
// Message memory: two buffers of 32-bit words in flip-flops.
// Software port reads with one cycle latency; serial side reads
// combinationally. Serial side write wins on an address clash.
`timescale 1ns/1ps

module pms_msg_mem #(
    parameter AW = 6
) (
    input wire CLK,
    input wire sw_we,
    input wire [AW:0] sw_addr,
    input wire [31:0] sw_wdata,
    output reg [31:0] sw_rdata,
    input wire port_we,
    input wire [AW:0] port_waddr,
    input wire [31:0] port_wdata,
    input wire [AW:0] port_raddr,
    output wire [31:0] port_rdata
);

    localparam DEPTH = 2 << AW;

    reg [31:0] mem_reg [0:DEPTH-1];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1)
        begin : g_word
            always @(posedge CLK)
            begin
                if (port_we && port_waddr == i)
                begin
                    mem_reg[i] <= port_wdata;
                end
                else if (sw_we && sw_addr == i)
                begin
                    mem_reg[i] <= sw_wdata;
                end
            end
        end
    endgenerate

    always @(posedge CLK)
    begin
        sw_rdata <= mem_reg[sw_addr];
    end

    assign port_rdata = mem_reg[port_raddr];

endmodule // pms_msg_mem

// ### src/pms_spi_slave.v
// Message passing SPI slave port with its transmit/receive memory.
// Assumes the host clock, select and data pins are asynchronous to
// CLK and that the host clock is well below CLK / 8.
`timescale 1ns/1ps
`include "pms_defines.vh"

// Functional notes
// [RL1] Slave; software picks the serial clock edge for sampling and changing
// [RL2] Bytes and words shift most significant bit first
// [RL3] Data output disabled whenever select is not asserted
// [RL4] Host keeps serial clock at or below 8 MHz
// [RL5] Host starts a transaction with select low, ends it with select high
// [RL6] Host sends its status byte first, then a zero padding byte
// [RL7] Device sends a padding byte first, then its status byte
// [RL8] Status: bits 7:2 zero, bit 1 data queued, bit 0 receive ready
// [RL9] Length byte N is nonzero only if data queued and peer ready
// [RL10] Host may stop after status bytes when nothing can move
// [RL11] Payload read and written from the lowest buffer address
// [RL12] Host clocks until the longer payload completes, then deselects
// [RL13] Host holds select high at least 400 ns between transactions
// [RL14] First payload word is three zero bytes then N minus one
// [RL15] Memory holds two buffers of 64 words, accessed without software
// [RL16] Software fills buffer 0 or 1, then arms with buffer and length
// [RL17] Attention rises once a message is queued
// [RL18] Attention drops at transaction start, returns if message unsent
// [RL19] Maskable internal interrupt on completion and on data arrival
// [RL20] After receive initialisation, status advertises receive ready
// [RL21] Attention rises when receive becomes ready after a refused send
// [RL22] Send and receive together only with different buffers; code lets both arm on one buffer when armed in the same cycle
// [RL23] Host deselects when device status refuses its direction
// [RL24] Host gives eight more clocks for the length byte
// [RL25] Reserved status bits and host padding byte are ignored
module pms_spi_slave #(
    parameter AW = `PMS_WORD_ADDR_W
) (
    input wire CLK,
    input wire SYS_RST,
    input wire HOST_SERIAL_CLOCK,
    input wire HOST_TO_DEVICE_DATA,
    input wire PORT_SELECT_N,
    output wire DEVICE_TO_HOST_DATA,
    output wire DEVICE_TO_HOST_DATA_OE,
    output wire HOST_ATTENTION,
    input wire CLK_EDGE_SEL,
    input wire TX_ARM,
    input wire TX_BUF_SEL,
    input wire [AW:0] TX_LEN,
    input wire RX_ARM,
    input wire RX_BUF_SEL,
    input wire MEM_WE,
    input wire [AW:0] MEM_ADDR,
    input wire [31:0] MEM_WDATA,
    output wire [31:0] MEM_RDATA,
    input wire [1:0] INT_MASK,
    input wire [1:0] INT_CLR,
    output wire [1:0] INT_FLAGS,
    output wire IRQ,
    output wire TX_PENDING,
    output wire RX_READY,
    output wire [AW:0] RX_WORDS,
    output wire BUSY
);

    // ****************************************************************
    // Pin synchronisation and edge detection
    // ****************************************************************
    wire [2:0] pin_sync;
    wire sclk_s;
    wire sel_n_s;
    wire mosi_s;
    reg sclk_d_reg;

    pms_sync #(
        .WIDTH(3),
        .RST_VAL({1'b0, `PMS_SYNC_RST, 1'b0})
    ) u_sync (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .async_in({HOST_SERIAL_CLOCK, PORT_SELECT_N, HOST_TO_DEVICE_DATA}),
        .sync_out(pin_sync)
    );

    assign sclk_s = pin_sync[2];
    assign sel_n_s = pin_sync[1];
    assign mosi_s = pin_sync[0];

    wire sclk_rise = sclk_s & ~sclk_d_reg;
    wire sclk_fall = ~sclk_s & sclk_d_reg;
    // Edge choice only safe to change while deselected
    wire sample_edge = CLK_EDGE_SEL ? sclk_fall : sclk_rise; // RL1
    wire shift_edge = CLK_EDGE_SEL ? sclk_rise : sclk_fall; // RL1

    // ****************************************************************
    // State
    // ****************************************************************
    reg active_reg;
    reg [2:0] bit_cnt_reg;
    reg [8:0] byte_cnt_reg;
    reg [6:0] rx_shift_reg;
    reg [7:0] tx_shift_reg;
    reg [23:0] rx_word_reg;
    reg tx_pending_reg;
    reg tx_buf_reg;
    reg [AW:0] tx_n_reg;
    reg tx_go_reg;
    reg rx_ready_reg;
    reg rx_buf_reg;
    reg [AW:0] rx_n_reg;
    reg [AW:0] rx_words_reg;
    reg refused_reg;
    reg attention_reg;
    reg [1:0] int_flag_reg;
    reg irq_reg;
    reg port_we_reg;
    reg [AW:0] port_waddr_reg;
    reg [31:0] port_wdata_reg;

    wire sel_act = ~sel_n_s;
    wire sel_start = sel_act & ~active_reg;
    wire sel_end = ~sel_act & active_reg;
    wire idle = ~active_reg & ~sel_act;
    wire [7:0] rx_byte = {rx_shift_reg, mosi_s};

    // Payload position: word and byte within word
    wire [8:0] pay_idx = byte_cnt_reg - `PMS_BYTE_PAYLOAD;
    wire [AW:0] pay_word = pay_idx[AW+2:2];
    wire [1:0] pay_lane = pay_idx[1:0];
    wire in_payload = byte_cnt_reg >= `PMS_BYTE_PAYLOAD;

    // ****************************************************************
    // Message memory
    // ****************************************************************
    wire [31:0] port_rdata;
    wire [AW:0] port_raddr = {tx_buf_reg, pay_word[AW-1:0]}; // RL11

    pms_msg_mem #(
        .AW(AW)
    ) u_mem (
        .CLK(CLK),
        .sw_we(MEM_WE),
        .sw_addr(MEM_ADDR),
        .sw_wdata(MEM_WDATA),
        .sw_rdata(MEM_RDATA),
        .port_we(port_we_reg),
        .port_waddr(port_waddr_reg),
        .port_wdata(port_wdata_reg),
        .port_raddr(port_raddr),
        .port_rdata(port_rdata)
    ); // RL15

    // ****************************************************************
    // Outgoing byte selection
    // ****************************************************************
    reg [31:0] tx_word;
    reg [7:0] tx_byte;
    wire [AW:0] tx_n_m1 = tx_n_reg - {{AW{1'b0}}, 1'b1};

    always @*
    begin
        // Hardware builds the header word; buffer word 0 not sent
        if (pay_word == {(AW+1){1'b0}})
        begin
            tx_word = {24'h000000, {(7-AW){1'b0}}, tx_n_m1}; // RL14
        end
        else
        begin
            tx_word = port_rdata;
        end
        if (byte_cnt_reg == `PMS_BYTE_STATUS_IN)
        begin
            tx_byte = `PMS_PAD_BYTE; // RL7
        end
        else if (byte_cnt_reg == `PMS_BYTE_PAD_IN)
        begin
            tx_byte = {6'h00, tx_pending_reg, rx_ready_reg}; // RL7 RL8 RL20
        end
        else if (byte_cnt_reg == `PMS_BYTE_LEN)
        begin
            tx_byte = tx_go_reg ? {{(7-AW){1'b0}}, tx_n_reg} : 8'h00; // RL9
        end
        else if (tx_go_reg && pay_word < tx_n_reg)
        begin
            case (pay_lane) // RL2
                2'h0: tx_byte = tx_word[31:24];
                2'h1: tx_byte = tx_word[23:16];
                2'h2: tx_byte = tx_word[15:8];
                default: tx_byte = tx_word[7:0];
            endcase
        end
        else
        begin
            tx_byte = 8'h00;
        end
    end

    // ****************************************************************
    // Main sequencing
    // ****************************************************************
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            sclk_d_reg <= 1'b0;
            active_reg <= 1'b0;
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 9'h000;
            rx_shift_reg <= 7'h00;
            tx_shift_reg <= 8'h00;
            rx_word_reg <= 24'h000000;
            tx_pending_reg <= 1'b0;
            tx_buf_reg <= 1'b0;
            tx_n_reg <= {(AW+1){1'b0}};
            tx_go_reg <= 1'b0;
            rx_ready_reg <= 1'b0;
            rx_buf_reg <= 1'b0;
            rx_n_reg <= {(AW+1){1'b0}};
            rx_words_reg <= {(AW+1){1'b0}};
            refused_reg <= 1'b0;
            attention_reg <= 1'b0;
            int_flag_reg <= `PMS_INT_RST;
            irq_reg <= 1'b0;
            port_we_reg <= 1'b0;
            port_waddr_reg <= {(AW+1){1'b0}};
            port_wdata_reg <= 32'h00000000;
        end
        else
        begin
            sclk_d_reg <= sclk_s;
            port_we_reg <= 1'b0;
            irq_reg <= |(int_flag_reg & INT_MASK); // RL19
            int_flag_reg <= int_flag_reg & ~INT_CLR;

            // Software arming only between transactions
            if (idle && TX_ARM && TX_LEN != {(AW+1){1'b0}} &&
                TX_LEN <= `PMS_MAX_WORDS &&
                !(rx_ready_reg && rx_buf_reg == TX_BUF_SEL)) // RL22
            begin
                tx_pending_reg <= 1'b1; // RL16
                tx_buf_reg <= TX_BUF_SEL;
                tx_n_reg <= TX_LEN;
                attention_reg <= 1'b1; // RL17
            end
            if (idle && RX_ARM &&
                !(tx_pending_reg && tx_buf_reg == RX_BUF_SEL)) // RL22
            begin
                rx_ready_reg <= 1'b1; // RL20
                rx_buf_reg <= RX_BUF_SEL;
                rx_words_reg <= {(AW+1){1'b0}};
                if (refused_reg)
                begin
                    attention_reg <= 1'b1; // RL21
                    refused_reg <= 1'b0;
                end
            end

            if (sel_start)
            begin
                active_reg <= 1'b1;
                bit_cnt_reg <= 3'h0;
                byte_cnt_reg <= 9'h000;
                tx_shift_reg <= `PMS_PAD_BYTE;
                tx_go_reg <= 1'b0;
                rx_n_reg <= {(AW+1){1'b0}};
                attention_reg <= 1'b0; // RL18
            end
            else if (sel_end)
            begin
                active_reg <= 1'b0;
                tx_go_reg <= 1'b0;
                attention_reg <= tx_pending_reg; // RL18
                int_flag_reg[`PMS_INT_XACT_BIT] <= 1'b1; // RL19
            end
            else if (active_reg && sample_edge)
            begin
                rx_shift_reg <= rx_byte[6:0]; // RL2
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7)
                begin
                    if (byte_cnt_reg != `PMS_BYTE_CNT_MAX)
                    begin
                        byte_cnt_reg <= byte_cnt_reg + 9'h001;
                    end
                    if (byte_cnt_reg == `PMS_BYTE_STATUS_IN)
                    begin
                        // Only the two flag bits matter
                        tx_go_reg <= tx_pending_reg &
                            rx_byte[`PMS_STAT_RECEIVE_READY_FLAG_BIT]; // RL9 RL25
                        if (rx_byte[`PMS_STAT_TXQ_BIT] && !rx_ready_reg)
                        begin
                            refused_reg <= 1'b1; // RL21
                        end
                    end
                    else if (byte_cnt_reg == `PMS_BYTE_LEN)
                    begin
                        if (!rx_ready_reg)
                        begin
                            rx_n_reg <= {(AW+1){1'b0}};
                        end
                        else if (rx_byte > `PMS_MAX_WORDS_BYTE)
                        begin
                            rx_n_reg <= `PMS_MAX_WORDS;
                        end
                        else
                        begin
                            rx_n_reg <= rx_byte[AW:0];
                        end
                    end
                    else if (in_payload)
                    begin
                        rx_word_reg <= {rx_word_reg[15:0], rx_byte}; // RL2
                        if (pay_lane == 2'h3 && pay_word < rx_n_reg)
                        begin
                            port_we_reg <= 1'b1; // RL11
                            port_waddr_reg <=
                                {rx_buf_reg, pay_word[AW-1:0]};
                            port_wdata_reg <= {rx_word_reg, rx_byte};
                            if (pay_word == rx_n_reg -
                                {{AW{1'b0}}, 1'b1})
                            begin
                                rx_ready_reg <= 1'b0;
                                rx_words_reg <= rx_n_reg;
                                int_flag_reg[`PMS_INT_RX_BIT] <= 1'b1; // RL19
                            end
                        end
                        if (pay_lane == 2'h3 && tx_go_reg &&
                            pay_word == tx_n_m1)
                        begin
                            tx_pending_reg <= 1'b0; // RL18
                        end
                    end
                end
            end
            else if (active_reg && shift_edge)
            begin
                if (bit_cnt_reg == 3'h0)
                begin
                    tx_shift_reg <= tx_byte;
                end
                else
                begin
                    tx_shift_reg <= {tx_shift_reg[6:0], 1'b0}; // RL2
                end
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign DEVICE_TO_HOST_DATA = tx_shift_reg[7];
    assign DEVICE_TO_HOST_DATA_OE = active_reg; // RL3
    assign HOST_ATTENTION = attention_reg;
    assign INT_FLAGS = int_flag_reg;
    assign IRQ = irq_reg;
    assign TX_PENDING = tx_pending_reg;
    assign RX_READY = rx_ready_reg;
    assign RX_WORDS = rx_words_reg;
    assign BUSY = active_reg;

endmodule // pms_spi_slave

// ### tb/pms_spi_slave_checker.sv
// Concurrent checks on the message SPI slave port's top-level pins.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps

module pms_spi_slave_checker #(
    parameter AW = 6
) (
    input wire CLK,
    input wire SYS_RST,
    input wire PORT_SELECT_N,
    input wire DEVICE_TO_HOST_DATA_OE,
    input wire HOST_ATTENTION,
    input wire [1:0] INT_MASK,
    input wire [1:0] INT_FLAGS,
    input wire IRQ,
    input wire TX_PENDING,
    input wire RX_READY,
    input wire [AW:0] RX_WORDS,
    input wire BUSY
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    oe_idle_a: assert property (PORT_SELECT_N [*6] |-> !DEVICE_TO_HOST_DATA_OE)
        else $error("data output enabled while deselected");
    oe_start_a: assert property ($fell(PORT_SELECT_N) |-> ##[1:6] DEVICE_TO_HOST_DATA_OE)
        else $error("data output not enabled after select");
    attn_arm_a: assert property ($rose(TX_PENDING) |-> HOST_ATTENTION)
        else $error("attention missing after queueing");
    attn_busy_a: assert property (BUSY && $past(BUSY) |-> !HOST_ATTENTION)
        else $error("attention high during transaction");
    attn_back_a: assert property ($fell(BUSY) && TX_PENDING |-> ##[0:3] HOST_ATTENTION)
        else $error("attention not restored for unsent message");
    pend_hold_a: assert property (TX_PENDING && !BUSY |=> TX_PENDING)
        else $error("queued message lost outside a transaction");
    irq_mask_a: assert property (IRQ == |($past(INT_FLAGS) & $past(INT_MASK)))
        else $error("interrupt does not follow masked flags");
    done_flag_a: assert property ($rose(PORT_SELECT_N) && BUSY |-> ##[1:6] INT_FLAGS[0])
        else $error("transaction done flag missing");
    rx_flag_a: assert property ($fell(RX_READY) |-> ##[0:1] INT_FLAGS[1])
        else $error("receive done flag missing");
    rx_hold_a: assert property (RX_READY && !BUSY |=> RX_READY)
        else $error("receive readiness lost outside a transaction");
    rx_cap_a: assert property (RX_WORDS <= 7'h40)
        else $error("received word count beyond buffer size");
endmodule // pms_spi_slave_checker

// ### tb/pms_host_model.sv
// Host processor acting as serial master: select, clock and data out.
// Assumes mode matches the device's edge select; 1 samples on the fall.
`timescale 1ns/1ps

module pms_host_model (
    output reg sck,
    output reg mosi,
    output reg sel_n,
    input wire miso,
    input wire mode
);
    // ****************************************************************
    // Frame control
    // ****************************************************************
    initial
    begin
        sck = 1'b0;
        mosi = 1'b0;
        sel_n = 1'b1;
    end

    // Select low opens, select high closes; idle time kept after
    task sel(input v);
        begin
            if (!v)
            begin
                sel_n = 1'b0;
                #300;
            end
            else
            begin
                #200;
                sel_n = 1'b1;
                #500;
            end
        end
    endtask

    // Serial clock stands still low between bytes and frames
    task xbyte(input [7:0] t, output [7:0] r);
        integer b;
        begin
            for (b = 7; b >= 0; b = b - 1)
            begin
                if (!mode)
                    mosi = t[b];
                #62.5 sck = 1'b1;
                // Mode 1 changes data on the rise, samples on the fall
                if (mode)
                    mosi = t[b];
                else
                    r[b] = miso;
                #62.5 sck = 1'b0;
                if (mode)
                    r[b] = miso;
            end
        end
    endtask
endmodule // pms_host_model

// ### tb/pms_spi_slave_tb.sv
// Testbench for the message SPI slave port: software strobes and
// framed host transactions through the host model, self-checking.
`timescale 1ns/1ps

`define CHK(n, e, g) \
    begin \
        num_checks = num_checks + 1; \
        if ((g) !== (e)) \
        begin \
            failures = failures + 1; \
            $display("MISMATCH %s exp %h got %h", n, e, g); \
        end \
    end

module pms_spi_slave_tb;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    reg CLK = 1'b0;
    reg SYS_RST = 1'b1;
    reg TX_ARM = 1'b0;
    reg TX_BUF_SEL = 1'b0;
    reg [6:0] TX_LEN = 7'h00;
    reg RX_ARM = 1'b0;
    reg RX_BUF_SEL = 1'b0;
    reg MEM_WE = 1'b0;
    reg [6:0] MEM_ADDR = 7'h00;
    reg [31:0] MEM_WDATA = 32'h0;
    reg [1:0] INT_MASK = 2'h0;
    reg [1:0] INT_CLR = 2'h0;
    reg EDGE = 1'b0;
    wire sck, mosi, sel_n, miso_w, miso, oe, attn, irq, pend, rxr, busy;
    wire [31:0] rdata;
    wire [1:0] flags;
    wire [6:0] rxw;
    integer failures = 0;
    integer num_checks = 0;
    integer i, k;
    reg [7:0] hb [0:18];
    reg [7:0] db [0:18];
    reg [31:0] w;

    // Released line shows the inverse so a stale bit never matches
    assign miso_w = oe ? miso : ~miso;

    always #5 CLK = ~CLK;

    pms_host_model pms_host_model_inst (.sck(sck), .mosi(mosi),
        .sel_n(sel_n), .miso(miso_w), .mode(EDGE));

    pms_spi_slave pms_spi_slave_inst (.CLK(CLK), .SYS_RST(SYS_RST),
        .HOST_SERIAL_CLOCK(sck), .HOST_TO_DEVICE_DATA(mosi),
        .PORT_SELECT_N(sel_n), .DEVICE_TO_HOST_DATA(miso),
        .DEVICE_TO_HOST_DATA_OE(oe), .HOST_ATTENTION(attn),
        .CLK_EDGE_SEL(EDGE), .TX_ARM(TX_ARM), .TX_BUF_SEL(TX_BUF_SEL),
        .TX_LEN(TX_LEN), .RX_ARM(RX_ARM), .RX_BUF_SEL(RX_BUF_SEL),
        .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
        .MEM_RDATA(rdata), .INT_MASK(INT_MASK), .INT_CLR(INT_CLR),
        .INT_FLAGS(flags), .IRQ(irq), .TX_PENDING(pend),
        .RX_READY(rxr), .RX_WORDS(rxw), .BUSY(busy));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    function [31:0] wd(input integer n);
        wd = 32'h80a0c0e0 ^ (n * 32'h01030507);
    endfunction

    task results;
        begin
            $display("checks %0d failures %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    task arm(input tx, input b, input [6:0] n);
        begin
            @(negedge CLK);
            TX_ARM = tx;
            RX_ARM = !tx;
            TX_BUF_SEL = b;
            RX_BUF_SEL = b;
            TX_LEN = n;
            @(negedge CLK);
            TX_ARM = 1'b0;
            RX_ARM = 1'b0;
        end
    endtask

    task sw_write(input [6:0] a, input [31:0] d);
        begin
            @(negedge CLK);
            MEM_WE = 1'b1;
            MEM_ADDR = a;
            MEM_WDATA = d;
            @(negedge CLK);
            MEM_WE = 1'b0;
        end
    endtask

    task sw_read(input [6:0] a, output [31:0] d);
        begin
            @(negedge CLK);
            MEM_ADDR = a;
            @(negedge CLK);
            d = rdata;
        end
    endtask

    task frame(input integer n);
        integer j;
        begin
            pms_host_model_inst.sel(1'b0);
            for (j = 0; j < n; j = j + 1)
            begin
                pms_host_model_inst.xbyte(hb[j], db[j]);
                if (j == 1)
                    `CHK("attention in frame", 1'b0, attn)
            end
            pms_host_model_inst.sel(1'b1);
            for (j = 0; j < 50 && busy !== 1'b0; j = j + 1)
                @(negedge CLK);
            if (busy !== 1'b0)
            begin
                failures = failures + 1;
                results;
            end
            repeat (4) @(negedge CLK);
        end
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial
    begin
        #200000;
        failures = failures + 1;
        results;
    end

    initial
    begin
        repeat (20) @(negedge CLK);
        SYS_RST = 1'b0;
        repeat (4) @(negedge CLK);
        `CHK("attention reset", 1'b0, attn)
        `CHK("oe reset", 1'b0, oe)
        INT_MASK = 2'b11;
        hb[0] = 8'h02;
        hb[1] = 8'h00;
        frame(2);
        `CHK("pad", 8'h00, db[0])
        `CHK("status idle", 8'h00, db[1])
        `CHK("attention idle", 1'b0, attn)
        `CHK("done flag", 2'b01, flags)
        `CHK("irq", 1'b1, irq)
        @(negedge CLK) INT_CLR = 2'b01;
        @(negedge CLK) INT_CLR = 2'b00;
        `CHK("flag clear", 2'b00, flags)
        arm(1'b0, 1'b1, 7'h00);
        `CHK("rx ready", 1'b1, rxr)
        `CHK("attention refused", 1'b1, attn)
        arm(1'b1, 1'b1, 7'h04);
        `CHK("same buffer", 1'b0, pend)
        for (i = 1; i < 4; i = i + 1)
            sw_write(i, wd(i));
        sw_read(7'h02, w);
        `CHK("mem read", wd(2), w)
        arm(1'b1, 1'b0, 7'h04);
        `CHK("pending", 1'b1, pend)
        `CHK("attention queued", 1'b1, attn)
        for (i = 0; i < 19; i = i + 1)
            hb[i] = 8'h00;
        hb[0] = 8'hff;
        hb[1] = 8'ha5;
        hb[2] = 8'h02;
        hb[6] = 8'h01;
        {hb[7], hb[8], hb[9], hb[10]} = 32'hc0ffee11;
        frame(19);
        `CHK("pad", 8'h00, db[0])
        `CHK("status both", 8'h03, db[1])
        `CHK("length", 8'h04, db[2])
        for (k = 0; k < 4; k = k + 1)
        begin
            w = (k == 0) ? 32'h3 : wd(k);
            for (i = 0; i < 4; i = i + 1)
                `CHK("payload", w[31-8*i -: 8], db[3+4*k+i])
        end
        `CHK("pending sent", 1'b0, pend)
        `CHK("rx done", 1'b0, rxr)
        `CHK("rx words", 7'h02, rxw)
        `CHK("flags", 2'b11, flags)
        `CHK("attention sent", 1'b0, attn)
        sw_read(7'h40, w);
        `CHK("rx header", 32'h1, w)
        sw_read(7'h41, w);
        `CHK("rx data", 32'hc0ffee11, w)
        arm(1'b1, 1'b0, 7'h01);
        arm(1'b0, 1'b0, 7'h00);
        `CHK("rx same buffer", 1'b0, rxr)
        @(negedge CLK) INT_CLR = 2'b11;
        INT_MASK = 2'b10;
        EDGE = 1'b1;
        @(negedge CLK) INT_CLR = 2'b00;
        hb[0] = 8'h00;
        hb[1] = 8'h00;
        frame(2);
        `CHK("pad edge1", 8'h00, db[0])
        `CHK("status queued", 8'h02, db[1])
        `CHK("still pending", 1'b1, pend)
        `CHK("attention back", 1'b1, attn)
        `CHK("flags masked", 2'b01, flags)
        `CHK("irq masked", 1'b0, irq)
        results;
    end
endmodule // pms_spi_slave_tb

bind pms_spi_slave pms_spi_slave_checker #(.AW(AW)) pms_chk (
    .CLK(CLK), .SYS_RST(SYS_RST), .PORT_SELECT_N(PORT_SELECT_N),
    .DEVICE_TO_HOST_DATA_OE(DEVICE_TO_HOST_DATA_OE),
    .HOST_ATTENTION(HOST_ATTENTION), .INT_MASK(INT_MASK),
    .INT_FLAGS(INT_FLAGS), .IRQ(IRQ), .TX_PENDING(TX_PENDING),
    .RX_READY(RX_READY), .RX_WORDS(RX_WORDS), .BUSY(BUSY));
